// *** include/cpc_pkg.sv ***
// constants and types for the core sequencing block
// assumes one instruction cycle enable from the decoder
package cpc_pkg;
    localparam int CPC_PC_W = 12;
    localparam int CPC_STACK_DEPTH = 4;
    localparam logic [11:0] CPC_PC_RESET = 12'h5FF;
    localparam logic [7:0] CPC_OPTION_RESET = 8'hFF;
    localparam logic [6:0] CPC_TRIM_RESET = 7'h7F;
    localparam logic [1:0] CPC_PAGE_RESET = 2'h0;
    localparam int CPC_OPT_CS_BIT = 5;
    localparam int CPC_OPT_SE_BIT = 4;
    localparam int CPC_OPT_PSA_BIT = 3;
    localparam int CPC_STAT_PAGE_LO = 5;
    localparam int CPC_STAT_C_BIT = 0;
    localparam int CPC_STAT_DC_BIT = 1;
    // ops that the decoder presents for one cycle
    typedef enum logic [2:0] {
        CPC_ALU_NONE,
        CPC_ALU_ADD,
        CPC_ALU_SUB,
        CPC_ALU_RRF,
        CPC_ALU_RLF
    } cpc_alu_op_t;
endpackage

// *** rtl/cpc_core_ctrl.sv ***
// program counter, stack, option and trim registers, flag logic
// assumes the decoder drives op strobes valid when cycle_en_in is high
// timer pin is external and asynchronous; it is double registered
`timescale 1ns/10ps
module cpc_core_ctrl import cpc_pkg::*; (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic cycle_en_in, // one pulse per instruction cycle
    input wire logic jump_op_in,
    input wire logic call_op_in,
    input wire logic return_with_literal_op_in,
    input wire logic pc_low_byte_wr_in,
    input wire logic option_load_in,
    input wire logic trim_wr_in,
    input wire logic [8:0] imm_in, // instruction immediate field
    input wire logic [7:0] result_in, // value bound for low byte
    input wire logic [7:0] working_in,
    input wire logic [7:0] wr_data_in,
    input wire logic [7:0] status_in, // page bits live here
    input wire logic status_wr_in,
    input wire cpc_alu_op_t alu_op_in,
    input wire logic [7:0] alu_a_in, // file register
    input wire logic [7:0] alu_b_in, // working register
    input wire logic carry_in,
    input wire logic external_timer_clock_pin_in,
    input wire logic port_direction_setting_in, // 1 = input
    output logic [CPC_PC_W-1:0] pc_out,
    output logic [7:0] pc_low_byte_out,
    output logic [1:0] page_select_bits_out,
    output logic [7:0] alu_result_out,
    output logic digit_carry_flag_out,
    output logic carry_flag_out,
    output logic flags_valid_out,
    output logic working_load_out,
    output logic [7:0] working_data_out,
    output logic [7:0] trim_out, // readable trim register
    output logic timer_pin_is_input_out,
    output logic timer_tick_out,
    output logic prescaler_to_wdt_out,
    output logic [2:0] prescaler_rate_out,
    output logic [8:0] timer_ratio_out,
    output logic [7:0] wdt_ratio_out,
    output logic pin_change_wake_disable_out,
    output logic weak_pullup_disable_out
);
    logic rst_s1_ff, rst_s2_ff; // reset release synchroniser
    logic rst_n;
    logic [CPC_PC_W-1:0] pc_ff, nxt_pc;
    logic [1:0] page_ff;
    logic [7:0] option_ff;
    logic [6:0] trim_ff;
    logic [CPC_PC_W-1:0] stack_top;
    logic push, pop;
    logic pin_s1_ff, pin_s2_ff, pin_d_ff; // timer pin sync and edge
    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] res;
    logic dc, cy, flags_v;
    logic pin_rise, pin_fall, tick;
    logic timer_pin_input_ff, tick_ff, valid_ff, wl_ff;
    logic [7:0] alu_res_ff, wdata_ff;
    logic dc_ff, cy_ff;
    logic [8:0] tratio_ff;
    logic [7:0] wratio_ff;

    // release reset through two flops, assert at once
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end
    assign rst_n = rst_s2_ff;

    assign push = cycle_en_in && call_op_in;
    assign pop = cycle_en_in && return_with_literal_op_in;

    cpc_stack #(
        .DEPTH(CPC_STACK_DEPTH),
        .W(CPC_PC_W)
    ) u_stack (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n),
        .push_in(push),
        .pop_in(pop),
        .push_data_in(pc_ff), // pc already points past the call
        .top_out(stack_top)
    );

    // next counter value; loads override the increment
    always_comb begin
        nxt_pc = pc_ff + 12'h001; // plain step
        if (pc_ff == CPC_PC_RESET) begin
            nxt_pc = '0; // reset word rolls over to zero
        end
        if (jump_op_in) begin
            nxt_pc = {1'b0, page_ff, imm_in};
        end else if (call_op_in) begin
            nxt_pc = {1'b0, page_ff, 1'b0, imm_in[7:0]};
        end else if (pc_low_byte_wr_in) begin
            nxt_pc = {1'b0, page_ff, 1'b0, result_in};
        end else if (return_with_literal_op_in) begin
            nxt_pc = stack_top;
        end
    end

    // program counter
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            pc_ff <= CPC_PC_RESET; // last word of last page
        end else if (cycle_en_in) begin
            pc_ff <= nxt_pc;
        end
    end

    // page bits mirrored from status writes
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            page_ff <= CPC_PAGE_RESET;
        end else if (cycle_en_in && status_wr_in) begin
            // code 11 is left to software to avoid
            page_ff <= status_in[CPC_STAT_PAGE_LO +: 2];
        end
    end

    // option register, loaded only from working
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            option_ff <= CPC_OPTION_RESET;
        end else if (cycle_en_in && option_load_in) begin
            option_ff <= working_in;
        end
    end

    // trim register, bit 0 not stored
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            trim_ff <= CPC_TRIM_RESET;
        end else if (cycle_en_in && trim_wr_in) begin
            trim_ff <= wr_data_in[7:1];
        end
    end

    // flag arithmetic; subtract is a plus not-w plus one
    always_comb begin
        sum9 = 9'h000;
        sum5 = 5'h00;
        res = 8'h00;
        dc = 1'b0;
        cy = 1'b0;
        flags_v = 1'b1;
        case (alu_op_in)
            CPC_ALU_ADD: begin
                sum9 = {1'b0, alu_a_in} + {1'b0, alu_b_in};
                sum5 = {1'b0, alu_a_in[3:0]} + {1'b0, alu_b_in[3:0]};
                res = sum9[7:0];
                dc = sum5[4];
                cy = sum9[8];
            end
            CPC_ALU_SUB: begin
                sum9 = {1'b0, alu_a_in} + {1'b0, ~alu_b_in} + 9'h001;
                sum5 = {1'b0, alu_a_in[3:0]} + {1'b0, ~alu_b_in[3:0]}
                    + 5'h01;
                res = sum9[7:0];
                dc = sum5[4]; // one means no borrow
                cy = sum9[8]; // one means no borrow
            end
            CPC_ALU_RRF: begin
                res = {carry_in, alu_a_in[7:1]};
                dc = 1'b0;
                cy = alu_a_in[0];
            end
            CPC_ALU_RLF: begin
                res = {alu_a_in[6:0], carry_in};
                dc = 1'b0;
                cy = alu_a_in[7];
            end
            default: begin
                flags_v = 1'b0;
            end
        endcase
    end

    // registered arithmetic outputs
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            alu_res_ff <= 8'h00;
            dc_ff <= 1'b0;
            cy_ff <= 1'b0;
            valid_ff <= 1'b0;
        end else begin
            valid_ff <= cycle_en_in && flags_v;
            if (cycle_en_in && flags_v) begin
                alu_res_ff <= res;
                dc_ff <= dc;
                cy_ff <= cy;
            end
        end
    end

    // working register load from return literal
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            wl_ff <= 1'b0;
            wdata_ff <= 8'h00;
        end else begin
            wl_ff <= pop;
            if (pop) begin
                wdata_ff <= imm_in[7:0];
            end
        end
    end

    // timer pin: two flops, then an edge flop
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_ff <= 1'b0;
            pin_s2_ff <= 1'b0;
            pin_d_ff <= 1'b0;
        end else begin
            pin_s1_ff <= external_timer_clock_pin_in;
            pin_s2_ff <= pin_s1_ff;
            pin_d_ff <= pin_s2_ff;
        end
    end
    assign pin_rise = pin_s2_ff && !pin_d_ff;
    assign pin_fall = !pin_s2_ff && pin_d_ff;

    // tick source: pin edge or instruction cycle
    always_comb begin
        if (option_ff[CPC_OPT_CS_BIT]) begin
            tick = option_ff[CPC_OPT_SE_BIT] ? pin_fall : pin_rise;
        end else begin
            tick = cycle_en_in;
        end
    end

    // timer side outputs and ratios
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            tick_ff <= 1'b0;
            timer_pin_input_ff <= 1'b1;
            tratio_ff <= 9'h100;
            wratio_ff <= 8'h80;
        end else begin
            tick_ff <= tick;
            // source select overrides direction
            timer_pin_input_ff <= option_ff[CPC_OPT_CS_BIT]
                || port_direction_setting_in;
            tratio_ff <= 9'h002 << option_ff[2:0];
            wratio_ff <= 8'h01 << option_ff[2:0];
        end
    end

    assign pc_out = pc_ff;
    assign pc_low_byte_out = pc_ff[7:0];
    assign page_select_bits_out = page_ff;
    assign alu_result_out = alu_res_ff;
    assign digit_carry_flag_out = dc_ff;
    assign carry_flag_out = cy_ff;
    assign flags_valid_out = valid_ff;
    assign working_load_out = wl_ff;
    assign working_data_out = wdata_ff;
    assign trim_out = {trim_ff, 1'b0};
    assign timer_pin_is_input_out = timer_pin_input_ff;
    assign timer_tick_out = tick_ff;
    assign prescaler_to_wdt_out = option_ff[CPC_OPT_PSA_BIT];
    assign prescaler_rate_out = option_ff[2:0];
    assign timer_ratio_out = tratio_ff;
    assign wdt_ratio_out = wratio_ff;
    assign pin_change_wake_disable_out = option_ff[7];
    assign weak_pullup_disable_out = option_ff[6];
endmodule

// *** rtl/cpc_stack.sv ***
// four level return address stack
// assumes push and pop never arrive together
`timescale 1ns/10ps
module cpc_stack import cpc_pkg::*; #(
    parameter int DEPTH = CPC_STACK_DEPTH,
    parameter int W = CPC_PC_W
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic push_in,
    input wire logic pop_in,
    input wire logic [W-1:0] push_data_in,
    output logic [W-1:0] top_out
);
    logic [W-1:0] lvl_ff [DEPTH]; // level 1 is index 0

    // shifting chain; silent on overflow and underflow
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                lvl_ff[i] <= '0;
            end
        end else if (push_in) begin
            lvl_ff[0] <= push_data_in;
            for (int i = 1; i < DEPTH; i++) begin
                lvl_ff[i] <= lvl_ff[i-1]; // oldest falls off
            end
        end else if (pop_in) begin
            // deepest holds, so repeats refill
            for (int i = 0; i < DEPTH - 1; i++) begin
                lvl_ff[i] <= lvl_ff[i+1];
            end
        end
    end

    assign top_out = lvl_ff[0];
endmodule

// *** testbench/cpc_core_asserts.sv ***
// port checks for the core sequencing block
// assumes one clock domain and the raw active low reset
`timescale 1ns/10ps
module cpc_core_asserts import cpc_pkg::*; (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic cycle_en_in,
    input wire logic jump_op_in,
    input wire logic call_op_in,
    input wire logic return_with_literal_op_in,
    input wire logic pc_low_byte_wr_in,
    input wire logic [8:0] imm_in,
    input wire cpc_alu_op_t alu_op_in,
    input wire logic [7:0] alu_a_in,
    input wire logic [7:0] alu_b_in,
    input wire logic [11:0] pc_out,
    input wire logic [7:0] pc_low_byte_out,
    input wire logic [1:0] page_select_bits_out,
    input wire logic [7:0] alu_result_out,
    input wire logic digit_carry_flag_out,
    input wire logic carry_flag_out,
    input wire logic flags_valid_out,
    input wire logic working_load_out,
    input wire logic [7:0] working_data_out,
    input wire logic [7:0] trim_out,
    input wire logic [2:0] prescaler_rate_out,
    input wire logic [8:0] timer_ratio_out,
    input wire logic [7:0] wdt_ratio_out
);
    // no counter load this cycle
    wire logic nop = !(jump_op_in | call_op_in |
        return_with_literal_op_in | pc_low_byte_wr_in);
    // nibble carry and nibble no-borrow of the operands
    wire logic dca = ({1'b0, alu_a_in[3:0]} + {1'b0, alu_b_in[3:0]}) > 5'h0F;
    wire logic dcs = alu_a_in[3:0] >= alu_b_in[3:0];
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    a_pc_idle_hold: assert property (!cycle_en_in |=> $stable(pc_out))
        else $error("counter moved without a cycle");
    a_pc_step_one: assert property (cycle_en_in && nop && pc_out != 12'h5FF
        |=> pc_out == $past(pc_out) + 12'h001)
        else $error("counter did not step by one");
    a_pc_reset_wrap: assert property (cycle_en_in && nop && pc_out == 12'h5FF
        |=> pc_out == 12'h000)
        else $error("counter did not wrap to zero");
    a_jump_load: assert property (cycle_en_in && jump_op_in
        |=> pc_out[8:0] == $past(imm_in)
        && pc_out[10:9] == $past(page_select_bits_out))
        else $error("jump target wrong");
    a_call_bit_eight: assert property (cycle_en_in && !jump_op_in
        && (call_op_in || pc_low_byte_wr_in) |=> !pc_out[8])
        else $error("counter bit 8 not cleared");
    a_low_byte_map: assert property (pc_low_byte_out == pc_out[7:0])
        else $error("low byte differs from counter");
    a_return_literal: assert property (cycle_en_in && !jump_op_in
        && return_with_literal_op_in && !call_op_in && !pc_low_byte_wr_in
        |=> working_load_out
        && {1'b0, working_data_out} == ($past(imm_in) & 9'h0FF))
        else $error("return literal not delivered");
    a_add_flags: assert property (cycle_en_in && alu_op_in == CPC_ALU_ADD
        |=> {carry_flag_out, alu_result_out} ==
        {1'b0, $past(alu_a_in)} + {1'b0, $past(alu_b_in)}
        && digit_carry_flag_out == $past(dca))
        else $error("add result or flags wrong");
    a_sub_flags: assert property (cycle_en_in && alu_op_in == CPC_ALU_SUB
        |=> alu_result_out == $past(alu_a_in) - $past(alu_b_in)
        && carry_flag_out == ($past(alu_a_in) >= $past(alu_b_in))
        && digit_carry_flag_out == $past(dcs))
        else $error("subtract result or flags wrong");
    a_flags_pulse: assert property (cycle_en_in
        && alu_op_in != CPC_ALU_NONE |=> flags_valid_out)
        else $error("flags valid pulse missing");
    a_trim_bit_zero: assert property (!trim_out[0])
        else $error("trim bit 0 not zero");
    a_ratio_match: assert property ($stable(prescaler_rate_out)
        |-> timer_ratio_out == (9'h002 << prescaler_rate_out)
        && wdt_ratio_out == (8'h01 << prescaler_rate_out))
        else $error("prescaler ratio wrong");
endmodule

// *** testbench/cpc_dec_model.sv ***
// stand-in for the decoder: issues cycle enables and status writes
// assumes the bench asks for one instruction at a time
`timescale 1ns/10ps
module cpc_dec_model (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic go_in, // bench asks for one cycle
    input wire logic st_req_in, // bench asks for a status write
    input wire logic [1:0] page_req_in,
    output logic cycle_en_out,
    output logic status_wr_out,
    output logic [7:0] status_out
);
    // enable launched one edge after the request, one cycle wide
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cycle_en_out <= 1'b0;
            status_wr_out <= 1'b0;
        end else begin
            cycle_en_out <= go_in;
            status_wr_out <= go_in & st_req_in;
        end
    end
    // reserved page code is folded to page 2, never written
    always_ff @(posedge mclk_in) begin
        status_out <= {1'b0, page_req_in & {1'b1, ~page_req_in[1]},
            5'h00};
    end
endmodule

// *** testbench/tb_top.sv ***
// self-checking bench for the core sequencing block
// assumes the decoder model supplies cycle enables and status writes
`timescale 1ns/10ps
module tb_top;
    import cpc_pkg::*;
    logic mclk_in = 0, rst_n_in = 0, go = 0, st_req = 0, cycle_en_in;
    logic jump_op_in = 0, call_op_in = 0, return_with_literal_op_in = 0;
    logic pc_low_byte_wr_in = 0, option_load_in = 0, trim_wr_in = 0;
    logic carry_in = 0, external_timer_clock_pin_in = 0, status_wr_in;
    logic port_direction_setting_in = 0, digit_carry_flag_out;
    logic [8:0] imm_in = 0, timer_ratio_out;
    logic [7:0] result_in = 0, working_in = 0, wr_data_in = 0, status_in;
    logic [7:0] alu_a_in = 0, alu_b_in = 0, pc_low_byte_out, alu_result_out;
    logic [7:0] working_data_out, trim_out, wdt_ratio_out;
    logic [1:0] pg = 0, page_select_bits_out;
    cpc_alu_op_t alu_op_in = CPC_ALU_NONE;
    logic [11:0] pc_out;
    logic carry_flag_out, flags_valid_out, working_load_out, timer_tick_out;
    logic timer_pin_is_input_out, prescaler_to_wdt_out;
    logic pin_change_wake_disable_out, weak_pullup_disable_out;
    logic [2:0] prescaler_rate_out;
    int errors = 0, n_checks = 0, cyc = 0, k;
    cpc_core_ctrl cpc_core_ctrl_i (.*);
    cpc_dec_model cpc_dec_model_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
        .go_in(go), .st_req_in(st_req), .page_req_in(pg),
        .cycle_en_out(cycle_en_in), .status_wr_out(status_wr_in),
        .status_out(status_in));
    // 200 MHz clock
    initial begin
        forever #2.5 mclk_in = ~mclk_in;
    end
    // hang guard, far above the 137 or so cycles the run needs
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            $display("unexpected at %0t: run did not finish", $time);
            wrap_up;
        end
    end
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one instruction cycle; strobes set beforehand, dropped after
    task automatic cyc1;
        go = 1;
        @(posedge mclk_in);
        #1 go = 0;
        @(posedge mclk_in);
        #1 {jump_op_in, call_op_in, return_with_literal_op_in} = 3'h0;
        {pc_low_byte_wr_in, option_load_in, trim_wr_in, st_req} = 4'h0;
        alu_op_in = CPC_ALU_NONE;
    endtask
    task automatic alu(input cpc_alu_op_t o, input logic [7:0] a, b,
        input logic ci, input logic [9:0] e);
        alu_op_in = o;
        alu_a_in = a;
        alu_b_in = b;
        carry_in = ci;
        cyc1;
        chk({carry_flag_out, digit_carry_flag_out, alu_result_out}, e);
    endtask
    task automatic opt(input logic [7:0] w);
        working_in = w;
        option_load_in = 1;
        cyc1;
        @(posedge mclk_in);
        #1;
    endtask
    // count timer ticks over eight cycles after a pin change
    task automatic pin(input logic v, input logic [11:0] e);
        logic [11:0] n;
        n = 0;
        external_timer_clock_pin_in = v;
        repeat (8) begin
            @(posedge mclk_in);
            #1 n += timer_tick_out;
        end
        chk(n, e);
    endtask
    task automatic wrap_up;
        if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge mclk_in);
        #1 rst_n_in = 1;
        repeat (4) @(posedge mclk_in);
        #1 chk(pc_out, 12'h5FF);
        chk(page_select_bits_out, 2'h0);
        chk(trim_out, 8'hFE);
        chk({pin_change_wake_disable_out, weak_pullup_disable_out,
            timer_pin_is_input_out, prescaler_to_wdt_out,
            prescaler_rate_out}, 7'h7F);
        cyc1;
        chk(pc_out, 12'h000);
        cyc1;
        chk(pc_out, 12'h001);
        // strobe without an enable is ignored
        jump_op_in = 1;
        repeat (2) @(posedge mclk_in);
        #1 jump_op_in = 0;
        chk(pc_out, 12'h001);
        for (k = 0; k < 3; k++) begin
            pg = 2'(k);
            st_req = 1;
            cyc1;
            jump_op_in = 1;
            imm_in = 9'h1AB;
            cyc1;
            chk(pc_out, {1'b0, pg, 9'h1AB});
        end
        result_in = 8'h9C;
        pc_low_byte_wr_in = 1;
        cyc1;
        chk(pc_out, 12'h49C);
        pg = 0;
        st_req = 1;
        cyc1;
        // five nested calls: only the newest four survive
        for (k = 1; k < 6; k++) begin
            call_op_in = 1;
            imm_in = {1'b1, 4'(k), 4'h0};
            cyc1;
            chk(pc_out, {4'h0, 4'(k), 4'h0});
        end
        for (k = 0; k < 6; k++) begin
            return_with_literal_op_in = 1;
            imm_in = 9'(8'hA0 + k);
            cyc1;
            chk(pc_out, 12'((k < 4 ? 4 - k : 1) * 16));
            chk(working_data_out, 8'(8'hA0 + k));
        end
        alu(CPC_ALU_ADD, 8'h0F, 8'h01, 0, 10'h110);
        alu(CPC_ALU_ADD, 8'hF8, 8'h08, 0, 10'h300);
        alu(CPC_ALU_SUB, 8'h10, 8'h01, 0, 10'h20F);
        alu(CPC_ALU_SUB, 8'h05, 8'h06, 1, 10'h0FF);
        alu(CPC_ALU_SUB, 8'h37, 8'h12, 0, 10'h325);
        alu(CPC_ALU_RRF, 8'h81, 8'h00, 0, 10'h240);
        alu(CPC_ALU_RLF, 8'h40, 8'h00, 1, 10'h081);
        for (k = 0; k < 8; k++) begin
            opt({2'(k), k[0], ~k[0], k[1], 3'(k)});
            chk({pin_change_wake_disable_out, weak_pullup_disable_out,
                timer_pin_is_input_out, prescaler_to_wdt_out,
                prescaler_rate_out},
                {working_in[7:5], working_in[3:0]});
            chk(timer_ratio_out, 12'h002 << k);
            chk(wdt_ratio_out, 12'h001 << k);
        end
        pin(1, 1);
        pin(0, 0);
        opt(8'h3F);
        pin(1, 0);
        pin(0, 1);
        opt(8'h1F);
        pin(1, 0);
        wr_data_in = 8'hA5;
        trim_wr_in = 1;
        cyc1;
        chk(trim_out, 8'hA4);
        chk(timer_tick_out, 1'b1);
        wrap_up;
    end
endmodule
bind cpc_core_ctrl cpc_core_asserts cpc_core_asserts_i (.*);
